/* fps_pkg.sv */
// Package of constants and types for the flash sequencer
`default_nettype none
package fps_pkg;
   localparam logic [23:0] P_IADDR_ADR = 24'hFFF940;
   localparam logic [23:0] P_IDATA_ADR = 24'hFFF942;
   localparam logic [23:0] P_SEC0_ADR = 24'hFFF944;
   localparam logic [23:0] P_SEC1_ADR = 24'hFFF946;
   localparam logic [23:0] P_CTRL_ADR = 24'hFFF94C;
   localparam logic [23:0] P_STAT_ADR = 24'hFFF94E;
   localparam logic [23:0] D_IADDR_ADR = 24'hFFF740;
   localparam logic [23:0] D_IDATA_ADR = 24'hFFF742;
   localparam logic [23:0] D_SEC_ADR = 24'hFFF744;
   localparam logic [23:0] D_CTRL_ADR = 24'hFFF74C;
   localparam logic [23:0] D_STAT_ADR = 24'hFFF74E;
   // Main block windows
   localparam logic [23:0] MAIN01_END = 24'h040000;
   localparam logic [23:0] MAIN2_BASE = 24'h0E0000;
   localparam logic [23:0] MAIN2_END = 24'h0E2000;
   localparam int MAIN1_BIT = 17;
   localparam int MAIN01_AW = 17;
   localparam int MAIN2_AW = 13;
   localparam int FL_AW = 18;
   // Section and boot geometry
   localparam int SEC_LSB_PROG = 13;
   localparam int SEC_LSB_DATA = 9;
   localparam int SEC_W = 4;
   localparam int BOOT_LSB = 10;
   localparam logic [2:0] BOOT_NONE = 3'h7;
   localparam int INFO1_BIT = 7;
   localparam int INFO1_SEC = 0;
   // Register fields and reset values
   localparam logic [7:0] IADDR_MASK_P = 8'hFE;
   localparam logic [7:0] IADDR_MASK_D = 8'h7E;
   localparam int CTRL_PROG = 0;
   localparam int CTRL_PAGE = 1;
   localparam int CTRL_BLOCK = 2;
   localparam int STAT_BUSY = 0;
   localparam int STAT_FULL = 1;
   localparam int STAT_EFAIL = 2;
   localparam int STAT_PFAIL = 3;
   localparam logic [15:0] SEC_RST = 16'h0000;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [7:0] IADDR_RST = 8'h00;
   localparam logic [1:0] SEL_WORD = 2'h3;

   typedef enum logic [1:0] {OP_READ, OP_PROG, OP_PAGE, OP_BLOCK} fps_op_t;
   typedef enum logic [2:0] {
      AR_MAIN0, AR_MAIN1, AR_MAIN2, AR_INFO0, AR_INFO1, AR_INFO2
   } fps_area_t;

   function automatic logic fps_majority(input logic [2:0] b);
      return (b[0] & b[1]) | (b[0] & b[2]) | (b[1] & b[2]);
   endfunction

   function automatic logic [15:0] fps_merge(input logic [15:0] old_v,
      input logic [15:0] new_v, input logic [1:0] sel);
      return {sel[1] ? new_v[15:8] : old_v[15:8],
              sel[0] ? new_v[7:0] : old_v[7:0]};
   endfunction
endpackage
`default_nettype wire

/* fps_chk_if.sv */
// Interface carrying a flash request to the permission checker
`timescale 1ns/1ps
`default_nettype none
interface fps_chk_if;
   fps_pkg::fps_op_t op;
   fps_pkg::fps_area_t area;
   logic [fps_pkg::FL_AW-1:0] addr;
   logic [2:0][15:0] sec;
   logic [2:0] lock;
   logic [2:0] boot;
   logic allow;
   modport req (output op, output area, output addr, output sec,
                output lock, output boot, input allow);
   modport chk (input op, input area, input addr, input sec,
                input lock, input boot, output allow);
endinterface
`default_nettype wire

/* fps_guard.sv */
// Permission check for flash erase and program requests
`timescale 1ns/1ps
`default_nettype none
module fps_guard (
   // Request under test
   fps_chk_if.chk c
);
   logic unlocked;
   logic boot_def;
   logic [2:0] boot_pages;
   logic [1:0] bank;
   logic [fps_pkg::SEC_W-1:0] sec_idx;
   logic sec_on;
   logic in_boot;
   logic is_main;
   logic prog_ok;

   assign unlocked = fps_pkg::fps_majority(c.lock);
   assign boot_def = c.boot != fps_pkg::BOOT_NONE;
   assign boot_pages = fps_pkg::BOOT_NONE - c.boot;
   assign bank = (c.area == fps_pkg::AR_MAIN0) ? 2'h0 :
                 (c.area == fps_pkg::AR_MAIN1 ||
                  c.area == fps_pkg::AR_INFO1) ? 2'h1 : 2'h2;
   assign sec_idx = (c.area == fps_pkg::AR_MAIN2) ?
      c.addr[fps_pkg::SEC_LSB_DATA +: fps_pkg::SEC_W] :
      c.addr[fps_pkg::SEC_LSB_PROG +: fps_pkg::SEC_W];
   assign sec_on = c.sec[bank][sec_idx];
   assign is_main = c.area == fps_pkg::AR_MAIN0 ||
                    c.area == fps_pkg::AR_MAIN1 ||
                    c.area == fps_pkg::AR_MAIN2;
   // Boot area sits at the bottom of block 0 in 1 KB units
   assign in_boot = c.area == fps_pkg::AR_MAIN0 &&
      c.addr[fps_pkg::FL_AW-1:fps_pkg::BOOT_LSB] < {5'h00, boot_pages};
   assign prog_ok = is_main ? (sec_on & ~in_boot) :
      (c.area == fps_pkg::AR_INFO1) ? c.sec[1][fps_pkg::INFO1_SEC] :
      (c.area == fps_pkg::AR_INFO2);

   always_comb
   begin
      case (c.op)
         fps_pkg::OP_READ: c.allow = 1'b1;
         fps_pkg::OP_PROG: c.allow = unlocked & prog_ok;
         fps_pkg::OP_PAGE: c.allow = unlocked & is_main & sec_on &
            ~in_boot;
         fps_pkg::OP_BLOCK: c.allow = unlocked & (&c.sec[bank]) &
            ~(bank == 2'h0 & boot_def) &
            (c.area != fps_pkg::AR_INFO0);
         default: c.allow = 1'b0;
      endcase
   end
endmodule // fps_guard
`default_nettype wire

/* fps_flash_seq.sv */
// Flash erase and program sequencer with Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module fps_flash_seq (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [23:1] wb_adr_i,
   input wire logic [1:0] wb_sel_i,
   input wire logic [15:0] wb_dat_i,
   output logic [15:0] wb_dat_o,
   output logic wb_ack_o,
   // Protection word fields
   input wire logic [2:0] wr_lock_bits_i,
   input wire logic [2:0] boot_area_code_i,
   // Flash array
   output logic fl_req_o,
   output logic [1:0] fl_op_o,
   output logic [2:0] fl_area_o,
   output logic [17:0] fl_addr_o,
   output logic [15:0] fl_wdata_o,
   input wire logic fl_done_i,
   input wire logic fl_fail_i,
   input wire logic [15:0] fl_rdata_i
);
   typedef enum logic {B_IDLE, B_READ} fps_bus_t;

   fps_bus_t bus_reg;
   logic [23:0] badr;
   logic req;
   logic hit_m01;
   logic hit_m2;
   logic hit_main;
   logic [1:0] hit_iaddr;
   logic [1:0] hit_idata;
   logic [1:0] hit_ctrl;
   logic [1:0] hit_stat;
   logic [2:0] hit_sec;
   logic w_mem;
   logic [2:0] w_ctrl;
   fps_pkg::fps_op_t c_op;
   fps_pkg::fps_area_t c_area;
   logic [fps_pkg::FL_AW-1:0] c_addr;
   logic c_mode;
   logic flash_acc;
   logic reg_acc;
   logic reg_wr;
   logic word_ok;
   logic permit;
   logic stall;
   logic go;
   logic free_now;
   logic issue_new;
   logic issue_pend;
   logic queue;
   logic ack_next;
   logic [15:0] rd_reg;
   logic [7:0] iaddr [2];
   logic [2:0] ctrl [2];
   logic [15:0] sec [3];
   logic [1:0] busy;
   logic [1:0] full;
   logic [1:0] efail;
   logic [1:0] pfail;
   logic cur_valid;
   logic cur_mem;
   logic pend_valid;
   logic pend_mem;
   fps_pkg::fps_area_t pend_area;
   logic [fps_pkg::FL_AW-1:0] pend_addr;
   logic [15:0] pend_data;

   function automatic logic [15:0] stat_word(input logic b, input logic f,
      input logic e, input logic p);
      logic [15:0] w;
      w = 16'h0000;
      w[fps_pkg::STAT_BUSY] = b;
      w[fps_pkg::STAT_FULL] = f;
      w[fps_pkg::STAT_EFAIL] = e;
      w[fps_pkg::STAT_PFAIL] = p;
      return w;
   endfunction

   fps_chk_if chk ();

   fps_guard u_guard (
      .c (chk)
   );

   // Address decode
   assign badr = {wb_adr_i, 1'b0};
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & (bus_reg == B_IDLE);
   assign hit_m01 = badr < fps_pkg::MAIN01_END;
   assign hit_m2 = (badr >= fps_pkg::MAIN2_BASE) &
                   (badr < fps_pkg::MAIN2_END);
   assign hit_main = hit_m01 | hit_m2;
   assign hit_iaddr = {badr == fps_pkg::D_IADDR_ADR,
                       badr == fps_pkg::P_IADDR_ADR};
   assign hit_idata = {badr == fps_pkg::D_IDATA_ADR,
                       badr == fps_pkg::P_IDATA_ADR};
   assign hit_ctrl = {badr == fps_pkg::D_CTRL_ADR,
                      badr == fps_pkg::P_CTRL_ADR};
   assign hit_stat = {badr == fps_pkg::D_STAT_ADR,
                      badr == fps_pkg::P_STAT_ADR};
   assign hit_sec = {badr == fps_pkg::D_SEC_ADR,
                     badr == fps_pkg::P_SEC1_ADR,
                     badr == fps_pkg::P_SEC0_ADR};
   assign flash_acc = req & (hit_main | (|hit_idata));
   assign reg_acc = req & ~(hit_main | (|hit_idata));
   assign reg_wr = reg_acc & wb_we_i;

   // Target memory, area and offset of a flash access
   assign w_mem = hit_main ? hit_m2 : hit_idata[1];
   assign w_ctrl = ctrl[w_mem];
   assign c_area = hit_m2 ? fps_pkg::AR_MAIN2 :
      hit_m01 ? (badr[fps_pkg::MAIN1_BIT] ? fps_pkg::AR_MAIN1 :
                 fps_pkg::AR_MAIN0) :
      hit_idata[1] ? fps_pkg::AR_INFO2 :
      iaddr[0][fps_pkg::INFO1_BIT] ? fps_pkg::AR_INFO1 :
      fps_pkg::AR_INFO0;
   assign c_addr = hit_m2 ?
      {{(fps_pkg::FL_AW - fps_pkg::MAIN2_AW){1'b0}},
       badr[fps_pkg::MAIN2_AW-1:0]} :
      hit_m01 ?
      {{(fps_pkg::FL_AW - fps_pkg::MAIN01_AW){1'b0}},
       badr[fps_pkg::MAIN01_AW-1:0]} :
      {10'h000, iaddr[w_mem]};

   // Operation chosen by the mode bits of the target memory
   assign c_op = ~wb_we_i ? fps_pkg::OP_READ :
      w_ctrl[fps_pkg::CTRL_PROG] ? fps_pkg::OP_PROG :
      w_ctrl[fps_pkg::CTRL_PAGE] ? fps_pkg::OP_PAGE :
      fps_pkg::OP_BLOCK;
   assign c_mode = ~wb_we_i | (|w_ctrl);

   assign chk.op = c_op;
   assign chk.area = c_area;
   assign chk.addr = c_addr;
   assign chk.sec = {sec[2], sec[1], sec[0]};
   assign chk.lock = wr_lock_bits_i;
   assign chk.boot = boot_area_code_i;

   // Programming takes only full aligned words
   assign word_ok = (c_op != fps_pkg::OP_PROG) |
                    (wb_sel_i == fps_pkg::SEL_WORD);
   assign permit = chk.allow & word_ok & c_mode;
   // Program waits only for a free pipeline slot; erase and read wait
   // for the whole sequencer to go idle
   assign stall = (c_op == fps_pkg::OP_PROG) ? pend_valid :
                  (cur_valid | pend_valid);
   assign go = flash_acc & permit & ~stall;
   assign free_now = ~cur_valid | (fl_done_i & ~pend_valid);
   assign issue_new = go & free_now;
   assign queue = go & ~free_now;
   assign issue_pend = fl_done_i & cur_valid & pend_valid;
   // Refused writes are answered at once and change nothing
   assign ack_next = reg_acc |
                     (flash_acc & wb_we_i & ~(permit & stall)) |
                     ((bus_reg == B_READ) & fl_done_i);

   // Register read mux
   assign rd_reg = hit_iaddr[0] ? {8'h00, iaddr[0]} :
                   hit_iaddr[1] ? {8'h00, iaddr[1]} :
                   hit_sec[0] ? sec[0] :
                   hit_sec[1] ? sec[1] :
                   hit_sec[2] ? sec[2] :
                   hit_ctrl[0] ? {13'h0000, ctrl[0]} :
                   hit_ctrl[1] ? {13'h0000, ctrl[1]} :
                   hit_stat[0] ?
                   stat_word(busy[0], full[0], efail[0], pfail[0]) :
                   hit_stat[1] ?
                   stat_word(busy[1], full[1], efail[1], pfail[1]) :
                   16'h0000;

   // Section enable registers
   for (genvar k = 0; k < 3; k++)
   begin : g_sec
      logic [15:0] sec_reg;
      assign sec[k] = sec_reg;
      always_ff @(posedge clk_i)
      begin
         if (srst_i)
            sec_reg <= fps_pkg::SEC_RST;
         else if (reg_wr & hit_sec[k])
            sec_reg <= fps_pkg::fps_merge(sec_reg, wb_dat_i, wb_sel_i);
      end
   end

   // Per-memory address, control and status state
   for (genvar m = 0; m < 2; m++)
   begin : g_mem
      logic [7:0] ia_reg;
      logic [2:0] ctl_reg;
      logic ef_reg;
      logic pf_reg;
      logic [7:0] ia_mask;
      logic [15:0] ia_merge;
      logic [15:0] ctl_merge;
      logic fin;
      logic set_e;
      logic set_p;
      logic clr_e;
      logic clr_p;

      assign ia_mask = (m == 0) ? fps_pkg::IADDR_MASK_P :
                       fps_pkg::IADDR_MASK_D;
      assign ia_merge = fps_pkg::fps_merge({8'h00, ia_reg}, wb_dat_i,
                                           wb_sel_i);
      assign ctl_merge = fps_pkg::fps_merge({13'h0000, ctl_reg},
                                            wb_dat_i, wb_sel_i);
      assign iaddr[m] = ia_reg;
      assign ctrl[m] = ctl_reg;
      assign busy[m] = (cur_valid & (fl_op_o != fps_pkg::OP_READ) &
                        (cur_mem == 1'(m))) |
                       (pend_valid & (pend_mem == 1'(m)));
      assign full[m] = pend_valid & (pend_mem == 1'(m));
      assign fin = fl_done_i & cur_valid & (cur_mem == 1'(m));
      assign set_e = fin & fl_fail_i &
                     ((fl_op_o == fps_pkg::OP_PAGE) |
                      (fl_op_o == fps_pkg::OP_BLOCK));
      assign set_p = fin & fl_fail_i &
                     (fl_op_o == fps_pkg::OP_PROG);
      assign clr_e = reg_wr & hit_stat[m] & wb_sel_i[0] &
                     wb_dat_i[fps_pkg::STAT_EFAIL];
      assign clr_p = reg_wr & hit_stat[m] & wb_sel_i[0] &
                     wb_dat_i[fps_pkg::STAT_PFAIL];

      always_ff @(posedge clk_i)
      begin
         if (srst_i)
         begin
            ia_reg <= fps_pkg::IADDR_RST;
            ctl_reg <= fps_pkg::CTRL_RST;
         end
         else
         begin
            // Bit 0 is held low: info words are always aligned
            if (reg_wr & hit_iaddr[m])
               ia_reg <= ia_merge[7:0] & ia_mask;
            if (reg_wr & hit_ctrl[m])
               ctl_reg <= ctl_merge[2:0];
         end
      end

      // Failure flags are sticky; a new failure beats a clear
      always_ff @(posedge clk_i)
      begin
         if (srst_i)
         begin
            ef_reg <= 1'b0;
            pf_reg <= 1'b0;
         end
         else
         begin
            ef_reg <= (ef_reg & ~clr_e) | set_e;
            pf_reg <= (pf_reg & ~clr_p) | set_p;
         end
      end
      assign efail[m] = ef_reg;
      assign pfail[m] = pf_reg;
   end

   // Flash command issue and write pipeline
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         fl_req_o <= 1'b0;
         fl_op_o <= fps_pkg::OP_READ;
         fl_area_o <= fps_pkg::AR_MAIN0;
         fl_addr_o <= '0;
         fl_wdata_o <= 16'h0000;
         cur_valid <= 1'b0;
         cur_mem <= 1'b0;
      end
      else
      begin
         fl_req_o <= issue_new | issue_pend;
         // Info area with block erase also clears its main block
         if (issue_new)
         begin
            fl_op_o <= c_op;
            fl_area_o <= c_area;
            fl_addr_o <= c_addr;
            fl_wdata_o <= wb_dat_i;
            cur_mem <= w_mem;
         end
         else if (issue_pend)
         begin
            fl_op_o <= fps_pkg::OP_PROG;
            fl_area_o <= pend_area;
            fl_addr_o <= pend_addr;
            fl_wdata_o <= pend_data;
            cur_mem <= pend_mem;
         end
         cur_valid <= issue_new | issue_pend | (cur_valid & ~fl_done_i);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         pend_valid <= 1'b0;
         pend_mem <= 1'b0;
         pend_area <= fps_pkg::AR_MAIN0;
         pend_addr <= '0;
         pend_data <= 16'h0000;
      end
      else
      begin
         pend_valid <= queue | (pend_valid & ~issue_pend);
         if (queue)
         begin
            pend_mem <= w_mem;
            pend_area <= c_area;
            pend_addr <= c_addr;
            pend_data <= wb_dat_i;
         end
      end
   end

   // Bus answer
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         bus_reg <= B_IDLE;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 16'h0000;
      end
      else
      begin
         wb_ack_o <= ack_next;
         if (go & ~wb_we_i)
            bus_reg <= B_READ;
         else if ((bus_reg == B_READ) & fl_done_i)
            bus_reg <= B_IDLE;
         if (reg_acc & ~wb_we_i)
            wb_dat_o <= rd_reg;
         else if ((bus_reg == B_READ) & fl_done_i)
            wb_dat_o <= fl_rdata_i;
      end
   end
endmodule // fps_flash_seq
`default_nettype wire

/* fps_flash_seq_sva.sv */
// Port-level assertions for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fps_flash_seq_sva (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [23:1] wb_adr_i,
   input wire logic [1:0] wb_sel_i,
   input wire logic [15:0] wb_dat_i,
   input wire logic [15:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Protection word fields
   input wire logic [2:0] wr_lock_bits_i,
   input wire logic [2:0] boot_area_code_i,
   // Flash array
   input wire logic fl_req_o,
   input wire logic [1:0] fl_op_o,
   input wire logic [2:0] fl_area_o,
   input wire logic [17:0] fl_addr_o,
   input wire logic [15:0] fl_wdata_o,
   input wire logic fl_done_i,
   input wire logic fl_fail_i,
   input wire logic [15:0] fl_rdata_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic busy_reg;
   logic rd_reg;
   wire logic unlocked = (wr_lock_bits_i[0] & wr_lock_bits_i[1]) |
      (wr_lock_bits_i[0] & wr_lock_bits_i[2]) |
      (wr_lock_bits_i[1] & wr_lock_bits_i[2]);
   wire logic wr_op = fl_req_o && fl_op_o != 2'h0;
   wire logic reg_hit = wb_cyc_i && wb_stb_i && !wb_ack_o &&
      wb_adr_i[7:1] != 7'h21 &&
      (wb_adr_i[23:8] == 16'hFFF9 || wb_adr_i[23:8] == 16'hFFF7);

   // Flash command in flight
   always_ff @(posedge clk_i)
   begin
      if (srst_i || fl_done_i)
      begin
         busy_reg <= 1'b0;
         rd_reg <= 1'b0;
      end
      else if (fl_req_o)
      begin
         busy_reg <= 1'b1;
         rd_reg <= fl_op_o == 2'h0;
      end
   end

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_reg_ack: assert property (reg_hit |=> wb_ack_o)
      else $error("register access not acked next cycle");
   a_one_op: assert property (fl_req_o |-> !busy_reg)
      else $error("flash command issued while one runs");
   a_req_pulse: assert property (fl_req_o |=> !fl_req_o)
      else $error("flash request longer than one cycle");
   a_read_answer: assert property (rd_reg && fl_done_i |=>
      wb_ack_o && wb_dat_o == $past(fl_rdata_i))
      else $error("read data not returned after flash answer");
   a_lock_blocks: assert property (wr_op |-> unlocked)
      else $error("flash altered while write locked");
   a_boot_kept: assert property (wr_op && !fl_area_o |->
      boot_area_code_i == 3'h7 || (fl_op_o != 2'h3 &&
      fl_addr_o[17:10] >= {5'h00, 3'h7 - boot_area_code_i}))
      else $error("boot area altered");
   a_info0_safe: assert property (fl_req_o && fl_area_o == 3'h3 |->
      fl_op_o == 2'h0)
      else $error("factory block altered");
   a_no_info_page: assert property (fl_req_o && fl_op_o == 2'h2 |->
      fl_area_o < 3'h3)
      else $error("page erase on information block");

   c_prog: cover property (fl_req_o && fl_op_o == 2'h1);
   c_page: cover property (fl_req_o && fl_op_o == 2'h2);
   c_block: cover property (fl_req_o && fl_op_o == 2'h3);
   c_read: cover property (rd_reg && fl_done_i);
endmodule // fps_flash_seq_sva

bind fps_flash_seq fps_flash_seq_sva u_sva (.clk_i, .srst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .wr_lock_bits_i, .boot_area_code_i, .fl_req_o, .fl_op_o, .fl_area_o,
   .fl_addr_o, .fl_wdata_o, .fl_done_i, .fl_fail_i, .fl_rdata_i);
`default_nettype wire

/* fps_flash_model.sv */
// Behavioural model of the flash array behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model #(
   parameter int LAT = 20
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Command from the sequencer
   input wire logic req_i,
   input wire logic [1:0] op_i,
   input wire logic [2:0] area_i,
   input wire logic [17:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic fail_inj_i,
   // Answer
   output logic done_o = 1'b0,
   output logic fail_o = 1'b0,
   output logic [15:0] rdata_o = 16'h0000
);
   logic [15:0] mem [int];
   logic [5:0] blank = 6'h00;
   int cnt = 0;
   int key;
   int pg;
   logic [1:0] op_q;
   logic [2:0] area_q;
   logic [17:0] addr_q;
   logic [15:0] wdata_q;

   // Words never written read as erased only after a block erase
   function automatic logic [15:0] peek(input int k);
      return mem.exists(k) ? mem[k] : (blank[k >> 18] ? 16'hFFFF : 16'h0000);
   endfunction

   always @(posedge clk_i)
   begin
      done_o <= 1'b0;
      fail_o <= 1'b0;
      rdata_o <= ~rdata_o;
      key = {area_q, addr_q[17:1], 1'b0};
      pg = (area_q == 3'h2) ? 512 : 1024;
      if (srst_i)
         cnt <= 0;
      else if (req_i)
      begin
         op_q <= op_i;
         area_q <= area_i;
         addr_q <= addr_i;
         wdata_q <= wdata_i;
         cnt <= LAT;
      end
      else if (cnt == 1)
      begin
         cnt <= 0;
         done_o <= 1'b1;
         fail_o <= fail_inj_i;
         case (op_q)
            2'h0: rdata_o <= peek(key);
            2'h1: mem[key] = peek(key) & wdata_q;
            2'h2:
               for (int j = 0; j < pg; j += 2)
                  mem[(key & ~(pg - 1)) + j] = 16'hFFFF;
            default:
            begin
               blank[area_q] = 1'b1;
               if (area_q >= 3'h3)
                  blank[area_q - 3'h3] = 1'b1;
               foreach (mem[k])
                  if (blank[k >> 18])
                     mem[k] = 16'hFFFF;
            end
         endcase
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule // fps_flash_model
`default_nettype wire

/* fps_flash_seq_tb_top.sv */
// Self-checking testbench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fps_flash_seq_tb_top;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [23:1] wb_adr_i = 23'h000000;
   logic [1:0] wb_sel_i = 2'h3;
   logic [15:0] wb_dat_i = 16'h0000;
   logic [2:0] wr_lock_bits_i = 3'h1;
   logic [2:0] boot_area_code_i = 3'h7;
   logic fail_inj = 1'b0;
   logic [15:0] wb_dat_o, fl_wdata_o, fl_rdata_i, q;
   logic wb_ack_o, fl_req_o, fl_done_i, fl_fail_i;
   logic [1:0] fl_op_o;
   logic [2:0] fl_area_o;
   logic [17:0] fl_addr_o;
   int n_mismatch = 0;
   int total_checks = 0;
   int n_req = 0;
   int cycles = 0;

   fps_flash_seq dut (.clk_i, .srst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wr_lock_bits_i,
      .boot_area_code_i, .fl_req_o, .fl_op_o, .fl_area_o, .fl_addr_o,
      .fl_wdata_o, .fl_done_i, .fl_fail_i, .fl_rdata_i);
   fps_flash_model #(.LAT(20)) u_flash (.clk_i, .srst_i, .req_i(fl_req_o),
      .op_i(fl_op_o), .area_i(fl_area_o), .addr_i(fl_addr_o),
      .wdata_i(fl_wdata_o), .fail_inj_i(fail_inj), .done_o(fl_done_i),
      .fail_o(fl_fail_i), .rdata_o(fl_rdata_i));

   initial forever #12.5 clk_i = ~clk_i;

   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk_i)
   begin
      cycles++;
      if (fl_req_o === 1'b1)
         n_req++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [23:0] a,
      input logic [15:0] d, input logic [1:0] s);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a[23:1];
      wb_sel_i <= s;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [23:0] a, input logic [15:0] d);
      wb(1'b1, a, d, 2'h3);
   endtask

   task automatic rd(input logic [23:0] a, input logic [15:0] e);
      wb(1'b0, a, 16'h0000, 2'h3);
      chk(q, e);
   endtask

   // Write that must start nothing in the array
   task automatic refuse(input logic [23:0] a, input logic [1:0] s);
      int r;
      r = n_req;
      wb(1'b1, a, 16'h0000, s);
      repeat (3) @(posedge clk_i);
      chk(16'(n_req), 16'(r));
   endtask

   // Poll a status bit, busy by default, until it reads clear
   task automatic wait_idle(input logic [23:0] a, input int b = 0);
      do wb(1'b0, a, 16'h0000, 2'h3); while (q[b] !== 1'b0);
   endtask

   initial
   begin
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(fps_pkg::P_SEC0_ADR, 16'h0000);
      rd(fps_pkg::P_SEC1_ADR, 16'h0000);
      rd(fps_pkg::D_SEC_ADR, 16'h0000);
      wr(fps_pkg::D_SEC_ADR, 16'hFFFF);
      wr(fps_pkg::D_CTRL_ADR, 16'h0004);
      refuse(24'h0E0000, 2'h3);
      wr_lock_bits_i <= 3'h6;
      wait_idle(fps_pkg::D_STAT_ADR);
      wr(fps_pkg::D_IDATA_ADR, 16'h0000);
      wait_idle(fps_pkg::D_STAT_ADR);
      rd(24'h0E0010, 16'hFFFF);
      rd(fps_pkg::D_IDATA_ADR, 16'hFFFF);
      wr(fps_pkg::D_CTRL_ADR, 16'h0002);
      refuse(fps_pkg::D_IDATA_ADR, 2'h3);
      wr(fps_pkg::D_CTRL_ADR, 16'h0001);
      wr(fps_pkg::D_IADDR_ADR, 16'h0006);
      wr(fps_pkg::D_IDATA_ADR, 16'hA5A5);
      wr(24'h0E0010, 16'h1234);
      wait_idle(fps_pkg::D_STAT_ADR, 1);
      wr(24'h0E0012, 16'h5678);
      rd(fps_pkg::D_STAT_ADR, 16'h0003);
      wait_idle(fps_pkg::D_STAT_ADR);
      rd(fps_pkg::D_STAT_ADR, 16'h0000);
      refuse(24'h0E0014, 2'h1);
      rd(24'h0E0010, 16'h1234);
      wb(1'b0, 24'h0E0013, 16'h0000, 2'h2);
      chk(q, 16'h5678);
      wr(fps_pkg::D_IADDR_ADR, 16'h0007);
      rd(fps_pkg::D_IDATA_ADR, 16'hA5A5);
      fail_inj <= 1'b1;
      wr(24'h0E0010, 16'hFF00);
      wait_idle(fps_pkg::D_STAT_ADR);
      rd(fps_pkg::D_STAT_ADR, 16'h0008);
      rd(24'h0E0010, 16'h1200);
      wr(fps_pkg::D_STAT_ADR, 16'h0008);
      rd(fps_pkg::D_STAT_ADR, 16'h0000);
      wr_lock_bits_i <= 3'h1;
      refuse(fps_pkg::D_IDATA_ADR, 2'h3);
      rd(fps_pkg::D_IDATA_ADR, 16'hA5A5);
      wr(fps_pkg::D_CTRL_ADR, 16'h0000);
      wr_lock_bits_i <= 3'h7;
      boot_area_code_i <= 3'h6;
      wr(fps_pkg::P_SEC0_ADR, 16'hFFFF);
      wr(fps_pkg::P_CTRL_ADR, 16'h0004);
      refuse(24'h000000, 2'h3);
      wr(fps_pkg::P_CTRL_ADR, 16'h0002);
      refuse(24'h0003FE, 2'h3);
      wait_idle(fps_pkg::P_STAT_ADR);
      wr(24'h000402, 16'h0000);
      wait_idle(fps_pkg::P_STAT_ADR);
      rd(fps_pkg::P_STAT_ADR, 16'h0004);
      fail_inj <= 1'b0;
      rd(24'h000400, 16'hFFFF);
      rd(24'h000800, 16'h0000);
      wr(fps_pkg::P_CTRL_ADR, 16'h0001);
      wr(fps_pkg::P_IADDR_ADR, 16'h0010);
      refuse(fps_pkg::P_IDATA_ADR, 2'h3);
      rd(fps_pkg::P_IDATA_ADR, 16'h0000);
      wr(fps_pkg::P_IADDR_ADR, 16'h0080);
      refuse(fps_pkg::P_IDATA_ADR, 2'h3);
      wr(fps_pkg::P_SEC0_ADR, 16'hFFFD);
      refuse(24'h002000, 2'h3);
      refuse(24'h000000, 2'h3);
      wr(fps_pkg::P_CTRL_ADR, 16'h0000);
      wrap_up();
   end
endmodule // fps_flash_seq_tb_top
`default_nettype wire
